/* src/uip_irq_unit.sv */
// Prioritised interrupt unit of an asynchronous serial element
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "uip_defs.svh"
module uip_irq_unit
  import uip_pkg::*;
(
  input  wire logic           clk,          // 50 MHz system clock
  input  wire logic           rst_n,        // Asynchronous reset, low
  input  wire uip_pkg::uip_addr_t addr,     // Register index
  input  wire uip_pkg::uip_byte_t wdata,    // Write data
  input  wire logic           wr,           // Write strobe
  input  wire logic           rd,           // Read strobe
  output      uip_pkg::uip_byte_t rdata,    // Read data, cycle after rd
  input  wire uip_pkg::uip_byte_t rx_byte,  // Byte from receive shifter
  input  wire logic           rx_load,      // Receive byte complete pulse
  input  wire logic           parity_err,   // Parity error with rx_load
  input  wire logic           framing_err,  // Framing error with rx_load
  input  wire logic           break_det,    // Break seen, pulse
  input  wire logic           tx_taken,     // Holding word moved to shifter
  input  wire logic           tx_shift_idle,// Shifter empty level
  input  wire logic [3:0]     modem_in,     // Live modem inputs dcd,ri,dsr,cts
  output      uip_pkg::uip_byte_t tx_byte,  // Held transmit byte
  output      logic           tx_load,      // Holding register written
  output      logic           irq_out       // Interrupt to host, high
);
  import uip_pkg::*;

  // Register map on the plain register port
  //   Index 0: read gives the receive buffer, write loads the holding byte
  //   Index 1: interrupt enable, four stored bits, upper bits read zero
  //   Index 2: interrupt identity, read only, writes are dropped
  //   Index 5: line status, read only, a read clears the error flags
  //   Index 6: modem status, live inputs high, delta bits low
  //   Every other index reads zero and ignores writes
  //
  // Bus timing
  //   A strobe is one cycle long and is taken on the rising edge
  //   Read data stand in the cycle after the strobe and only there
  //   Outside that cycle the read data port shows zero
  //   Strobes may follow back to back; the slave never stalls
  //
  // Interrupt sources, highest first
  //   Line errors: overrun, parity, framing and break flags
  //   Received data: the ready flag while a byte waits in the buffer
  //   Transmit empty: a latch armed when the held byte moves out
  //   Modem change: any of the four delta indicators
  //
  // Identity values seen by the host
  //   Idle 0x01, line 0x06, receive 0x04, transmit 0x02, modem 0x00
  //   Bit 0 is the inverse of the interrupt output, so software may
  //   either poll it or use the whole byte as a jump table index
  //
  // Priority handling
  //   The identity is a pure function of the pending flags, so a lower
  //   source stays hidden while a higher one is still pending
  //   Nothing here latches a reported source; servicing the flag that
  //   raised it, or clearing its enable bit, uncovers the next one
  //   The read data register freezes the identity seen at the strobe
  //
  // Clearing actions
  //   Line status read clears overrun, parity, framing and break
  //   Receive buffer read clears the ready flag
  //   Modem status read clears the deltas, never the live bits
  //   Transmit empty clears on a holding write, or on an identity read
  //   made while it is the reported source
  //
  // Set and clear in one cycle
  //   Every flag gives the set priority over the clear, so an event
  //   that lands on the clearing read is never lost; the host sees it
  //   on its next pass instead
  //   Overrun is the exception by nature: a buffer read in the same
  //   cycle as a new byte means no byte was overwritten
  //
  // Transmit empty latch
  //   It arms only on the move pulse from the shifter, not on the
  //   level of the holding empty flag
  //   This keeps an identity read from being undone one cycle later
  //   while the holding register is still empty
  //   Limitation: after reset the holding register is empty but no
  //   interrupt is raised until a byte has been written and moved
  //
  // Enables
  //   Disabling a source only masks it; its flag keeps working, so
  //   unmasking later reports anything that happened meanwhile
  //   With all enables low the identity reads idle and the output
  //   stays low
  //
  // Modem deltas
  //   Each live input is compared with its copy from the last cycle
  //   Three inputs flag any change; the ring input flags only the
  //   falling live bit, the trailing edge of its inverted pin
  //   Inputs are taken as already synchronous to the clock
  //
  // Output timing
  //   All outputs come from flops; the interrupt output follows the
  //   pending flags one cycle late, which costs a cycle of latency
  //   but keeps the pin free of decode glitches
  //   The held byte and its load pulse follow a data write by a cycle
  //
  // Reset
  //   The external reset asserts at once and is released through two
  //   flops; requests are safe from the third edge after release

  // Reset release through two flops
  logic       rst_meta;
  logic       rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Access decode, used by several processes
  function automatic logic hit(input logic s, input uip_addr_t a,
                               input logic [2:0] ofs);
    hit = s && (a == ofs);
  endfunction

  logic rd_data, rd_ident, rd_line, rd_modem, wr_data, wr_en;
  assign rd_data  = hit(rd, addr, `UIP_OFS_DATA);
  assign rd_ident = hit(rd, addr, `UIP_OFS_IDENTITY);
  assign rd_line  = hit(rd, addr, `UIP_OFS_LINE_STAT);
  assign rd_modem = hit(rd, addr, `UIP_OFS_MODEM_ST);
  assign wr_data  = hit(wr, addr, `UIP_OFS_DATA);
  assign wr_en    = hit(wr, addr, `UIP_OFS_ENABLE);

  // State registers
  logic [3:0] enable;       // Only four stored bits; upper read zero
  uip_byte_t  rx_buf;       // Receive buffer
  logic       rx_ready_flag;
  logic       overrun_flag;
  logic       parity_err_flag;
  logic       framing_err_flag;
  logic       break_flag;
  logic       tx_holding_empty;
  logic       tx_irq;       // Transmit empty interrupt latch
  logic [3:0] modem_prev;   // Last sampled modem inputs
  logic [3:0] modem_delta;  // Delta indicators
  uip_byte_t  tx_hold;

  logic [3:0] next_enable;
  uip_byte_t  next_rx_buf;
  logic       next_rx_ready_flag, next_overrun_flag, next_parity_err_flag;
  logic       next_framing_err_flag, next_break_flag;
  logic       next_tx_holding_empty, next_tx_irq;
  logic [3:0] next_modem_prev, next_modem_delta;
  uip_byte_t  next_tx_hold;
  uip_byte_t  next_rdata;
  logic       next_irq_out;
  logic       next_tx_load;

  // Pending sources after enable gating
  logic       p_line, p_rxd, p_tx, p_modem, any_pend;
  uip_src_t   src;
  uip_byte_t  ident;
  uip_byte_t  line_status;
  uip_byte_t  modem_status;

  always_comb begin
    // Gate each source by its enable bit
    p_line  = enable[`UIP_EN_LINEERR] & (overrun_flag | parity_err_flag |
              framing_err_flag | break_flag);
    p_rxd   = enable[`UIP_EN_RXDATA] & rx_ready_flag;
    p_tx    = enable[`UIP_EN_TXEMPTY] & tx_irq;
    p_modem = enable[`UIP_EN_MODEM] & (|modem_delta);
    any_pend = p_line | p_rxd | p_tx | p_modem;
    // Fixed priority; lower source is hidden until higher one clears
    if (p_line)      src = UIP_SRC_LINEERR;
    else if (p_rxd)  src = UIP_SRC_RXDATA;
    else if (p_tx)   src = UIP_SRC_TXEMPTY;
    else             src = UIP_SRC_MODEM;
    // Bits 7:3 zero, bit 0 low while pending
    ident = any_pend ? {5'h00, src, 1'b0}
                     : `UIP_IDLE_IDENT;
    line_status = {1'b0, tx_holding_empty & tx_shift_idle,
                   tx_holding_empty, break_flag, framing_err_flag,
                   parity_err_flag, overrun_flag, rx_ready_flag};
    modem_status = {modem_in, modem_delta};
  end

  // Next state of flags and registers
  always_comb begin
    next_enable = wr_en ? wdata[3:0] : enable;
    next_tx_hold = wr_data ? wdata : tx_hold;
    next_tx_load = wr_data;
    // Receive side: load sets ready, read clears; a load wins
    next_rx_buf = rx_load ? rx_byte : rx_buf;
    next_rx_ready_flag = rx_load | (rx_ready_flag & ~rd_data);
    // Line errors set regardless of enables, cleared by status read
    next_overrun_flag = (rx_load & rx_ready_flag & ~rd_data) |
                        (overrun_flag & ~rd_line);
    next_parity_err_flag  = (rx_load & parity_err) |
                            (parity_err_flag & ~rd_line);
    next_framing_err_flag = (rx_load & framing_err) |
                            (framing_err_flag & ~rd_line);
    next_break_flag = break_det | (break_flag & ~rd_line);
    // Holding empty: a move to the shifter sets it, a write clears it
    next_tx_holding_empty = tx_taken | (tx_holding_empty & ~wr_data);
    // Tx interrupt arms on the move pulse only; clears on write or on a
    // read of the identity while it is the reported source
    next_tx_irq = tx_taken |
                  (tx_irq & ~wr_data &
                   ~(rd_ident && any_pend && src == UIP_SRC_TXEMPTY));
    // Modem deltas: changes set, read clears, change wins
    next_modem_prev = modem_in;
    next_modem_delta[0] = (modem_in[0] ^ modem_prev[0]) |
                          (modem_delta[0] & ~rd_modem);
    next_modem_delta[1] = (modem_in[1] ^ modem_prev[1]) |
                          (modem_delta[1] & ~rd_modem);
    // Ring: only the trailing edge, live bit falling
    next_modem_delta[2] = (~modem_in[2] & modem_prev[2]) |
                          (modem_delta[2] & ~rd_modem);
    next_modem_delta[3] = (modem_in[3] ^ modem_prev[3]) |
                          (modem_delta[3] & ~rd_modem);
    // Read mux, answered one cycle after the strobe
    next_rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `UIP_OFS_DATA:      next_rdata = rx_buf;
        `UIP_OFS_ENABLE:    next_rdata = {4'h0, enable};
        `UIP_OFS_IDENTITY:  next_rdata = ident;
        `UIP_OFS_LINE_STAT: next_rdata = line_status;
        `UIP_OFS_MODEM_ST:  next_rdata = modem_status;
        default:            next_rdata = 8'h00;
      endcase
    end
    next_irq_out = any_pend;
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      enable           <= `UIP_ENABLE_RST;
      rx_buf           <= 8'h00;
      rx_ready_flag    <= 1'b0;
      overrun_flag     <= 1'b0;
      parity_err_flag  <= 1'b0;
      framing_err_flag <= 1'b0;
      break_flag       <= 1'b0;
      tx_holding_empty <= 1'b1;
      tx_irq           <= 1'b0;
      modem_prev       <= 4'h0;
      modem_delta      <= 4'h0;
      tx_hold          <= 8'h00;
      tx_byte          <= 8'h00;
      tx_load          <= 1'b0;
      rdata            <= 8'h00;
      irq_out          <= 1'b0;
    end else begin
      enable           <= next_enable;
      rx_buf           <= next_rx_buf;
      rx_ready_flag    <= next_rx_ready_flag;
      overrun_flag     <= next_overrun_flag;
      parity_err_flag  <= next_parity_err_flag;
      framing_err_flag <= next_framing_err_flag;
      break_flag       <= next_break_flag;
      tx_holding_empty <= next_tx_holding_empty;
      tx_irq           <= next_tx_irq;
      modem_prev       <= next_modem_prev;
      modem_delta      <= next_modem_delta;
      tx_hold          <= next_tx_hold;
      tx_byte          <= next_tx_hold;
      tx_load          <= next_tx_load;
      rdata            <= next_rdata;
      irq_out          <= next_irq_out;
    end
  end

  // Checks
  a_ident_bit0: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident |=> rdata[0] == $past(!any_pend))
    else $error("identity bit 0 wrong");
  a_ident_prio: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident && p_line |=> rdata == 8'h06)
    else $error("line error not reported first");
  a_ident_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident && !any_pend |=> rdata == 8'h01)
    else $error("idle identity wrong");
  a_ident_high: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident |=> rdata[7:3] == 5'h00)
    else $error("identity upper bits set");
  a_irq_mirror: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident |=> irq_out == !rdata[0])
    else $error("irq does not mirror identity");
  a_rx_code: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident && !p_line && p_rxd |=> rdata == 8'h04)
    else $error("rx data code wrong");
  a_tx_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident && src == UIP_SRC_TXEMPTY && any_pend && !tx_taken
    |=> !tx_irq)
    else $error("tx irq not cleared by identity read");
  a_rx_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_data && !rx_load |=> !rx_ready_flag)
    else $error("ready flag not cleared");
  a_disabled: assert property (@(posedge clk) disable iff (!rst_sync_n)
    enable == 4'h0 |=> !irq_out)
    else $error("irq while disabled");
  a_en_upper: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd && addr == `UIP_OFS_ENABLE |=> rdata[7:4] == 4'h0)
    else $error("enable upper bits set");
  // Transmit code while both higher sources are quiet
  a_tx_code: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident && !p_line && !p_rxd && p_tx |=> rdata == 8'h02)
    else $error("tx code wrong");
  // Modem code only when it is the sole source
  a_modem_code: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_ident && p_modem && !p_line && !p_rxd && !p_tx
    |=> rdata == 8'h00)
    else $error("modem code wrong");
  // Line status read empties every error flag when no new event lands
  a_line_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_line && !rx_load && !break_det |=> !overrun_flag &&
    !parity_err_flag && !framing_err_flag && !break_flag)
    else $error("line flags not cleared");
  // Modem read clears deltas when the inputs hold still
  a_modem_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_modem && modem_in == modem_prev |=> modem_delta == 4'h0)
    else $error("modem deltas not cleared");
  // Live bits shown as they stood at the strobe
  a_modem_live: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rd_modem |=> rdata[7:4] == $past(modem_in))
    else $error("modem live bits wrong");
  // No move pulse, no new transmit interrupt
  a_tx_rearm: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !tx_irq && !tx_taken |=> !tx_irq)
    else $error("tx irq raised without move");
  // Move pulse sets the empty flag and arms the latch
  a_tx_holding_empty_set: assert property (@(posedge clk) disable iff (!rst_sync_n)
    tx_taken |=> tx_holding_empty && tx_irq)
    else $error("holding empty not set");
  // Parity error flag sets regardless of the enables
  a_flag_masked: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rx_load && parity_err |=> parity_err_flag)
    else $error("parity flag not set");
  // Received data outranks transmit and modem
  a_rx_over_tx: assert property (@(posedge clk) disable iff (!rst_sync_n)
    p_rxd && !p_line |-> src == UIP_SRC_RXDATA)
    else $error("rx data not ranked second");
  // Output follows any enabled pending source
  a_irq_follow: assert property (@(posedge clk) disable iff (!rst_sync_n)
    any_pend |=> irq_out)
    else $error("irq not raised");
  // Scenarios worth seeing
  c_tx_irq: cover property (@(posedge clk) tx_taken ##1 p_tx ##1 irq_out);
  c_rx_then_tx: cover property (@(posedge clk) p_rxd && p_tx);
  c_line_over_rx: cover property (@(posedge clk) p_line && p_rxd);
  c_modem_clear: cover property (@(posedge clk) p_modem ##1 rd_modem);
endmodule // uip_irq_unit

/* src/uip_defs.svh */
// Register offsets, field positions and reset values of the interrupt unit
`ifndef UIP_DEFS_SVH
`define UIP_DEFS_SVH
// Register indices on the plain register port
`define UIP_OFS_DATA      3'h0
`define UIP_OFS_ENABLE    3'h1
`define UIP_OFS_IDENTITY  3'h2
`define UIP_OFS_LINE_STAT 3'h5
`define UIP_OFS_MODEM_ST  3'h6
// Enable register field positions
`define UIP_EN_RXDATA     0
`define UIP_EN_TXEMPTY    1
`define UIP_EN_LINEERR    2
`define UIP_EN_MODEM      3
// Line status field positions
`define UIP_LS_READY      0
`define UIP_LS_OVERRUN    1
`define UIP_LS_PARITY     2
`define UIP_LS_FRAMING    3
`define UIP_LS_BREAK      4
`define UIP_LS_THEMPTY    5
`define UIP_LS_TEMPTY     6
// Reset values
`define UIP_ENABLE_RST    4'h0
`define UIP_IDLE_IDENT    8'h01
`endif

/* src/uip_pkg.sv */
// Types shared by the interrupt unit
package uip_pkg;
  // Identity codes in bits 2:1 of the identity register
  typedef enum logic [1:0] {
    UIP_SRC_MODEM   = 2'b00,
    UIP_SRC_TXEMPTY = 2'b01,
    UIP_SRC_RXDATA  = 2'b10,
    UIP_SRC_LINEERR = 2'b11
  } uip_src_t;
  typedef logic [2:0] uip_addr_t;
  typedef logic [7:0] uip_byte_t;
endpackage

/* verification/uip_line_model.sv */
// Line-side partner of the interrupt unit: shifters and modem pins
`timescale 1ns/1ns
module uip_line_model
  import uip_pkg::*;
#(
  parameter int TAKE_DLY = 6  // Cycles from a holding load to the move
)(
  input  wire logic           clk,           // System clock
  input  wire logic           tx_load,       // Holding register written
  output uip_pkg::uip_byte_t  rx_byte,       // Assembled receive byte
  output logic                rx_load,       // Byte complete pulse
  output logic                parity_err,    // Parity error with rx_load
  output logic                framing_err,   // Framing error with rx_load
  output logic                break_det,     // Break seen, pulse
  output logic                tx_taken,      // Held word moved to shifter
  output logic                tx_shift_idle, // Shifter empty level
  output logic [3:0]          modem_in       // Live modem pins
);
  int cnt = 0;  // Countdown to the move into the shifter
  initial begin
    rx_byte = 8'hff;
    {rx_load, parity_err, framing_err, break_det, tx_taken} = 5'h00;
    tx_shift_idle = 1'b1;
    modem_in = 4'h0;
  end
  // Slow shifter: the held word leaves only after TAKE_DLY cycles
  always @(posedge clk) begin
    tx_taken <= (cnt == 1);
    tx_shift_idle <= (cnt == 0);
    if (tx_load)
      cnt <= TAKE_DLY;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  // One received byte; flags are only meaningful beside the pulse
  task automatic recv(input uip_byte_t b, input logic pe, input logic fe);
    @(posedge clk);
    {rx_byte, parity_err, framing_err, rx_load} <= {b, pe, fe, 1'b1};
    @(posedge clk);
    {rx_byte, parity_err, framing_err, rx_load} <= {~b, 3'b000};
  endtask
  // Break seen on the line: a one-cycle pulse
  task automatic brk();
    @(posedge clk);
    break_det <= 1'b1;
    @(posedge clk);
    break_det <= 1'b0;
  endtask
  // Modem pins change just after an edge
  task automatic set_modem(input logic [3:0] v);
    @(posedge clk);
    modem_in <= v;
  endtask
endmodule // uip_line_model

/* verification/uip_irq_unit_bench.sv */
// Self-checking bench of the interrupt unit
`timescale 1ns/1ns
`include "uip_defs.svh"
module uip_irq_unit_bench;
  import uip_pkg::*;
  logic       clk = 1'b0;    // 50 MHz clock
  logic       rst_n = 1'b0;  // Reset, low at start
  uip_addr_t  addr = 3'h0;   // Register index
  uip_byte_t  wdata = 8'h00; // Write data
  logic       wr = 1'b0;     // Write strobe
  logic       rd = 1'b0;     // Read strobe
  uip_byte_t  rdata, rx_byte, tx_byte, got;
  logic       rx_load, parity_err, framing_err, break_det;
  logic       tx_taken, tx_shift_idle, tx_load, irq_out;
  logic [3:0] modem_in;
  int         mismatches = 0;
  int         check_count = 0;
  uip_irq_unit u_uip_irq_unit (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_byte(rx_byte),
    .rx_load(rx_load), .parity_err(parity_err), .framing_err(framing_err),
    .break_det(break_det), .tx_taken(tx_taken),
    .tx_shift_idle(tx_shift_idle), .modem_in(modem_in),
    .tx_byte(tx_byte), .tx_load(tx_load), .irq_out(irq_out));
  uip_line_model u_uip_line_model (.clk(clk), .tx_load(tx_load),
    .rx_byte(rx_byte), .rx_load(rx_load), .parity_err(parity_err),
    .framing_err(framing_err), .break_det(break_det),
    .tx_taken(tx_taken), .tx_shift_idle(tx_shift_idle),
    .modem_in(modem_in));
  always #10 clk = ~clk;
  // Closing report, the only place the run ends
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, exp, input string m);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, m, seen, exp);
    end
  endtask
  // Single-cycle bus strobes, changed just after an edge
  task automatic reg_wr(input uip_addr_t a, input uip_byte_t d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input uip_addr_t a, input uip_byte_t e, string m);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(got, e, m);
  endtask
  // Bounded wait for the interrupt output to reach a level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_out !== lvl && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    if (irq_out !== lvl) begin
      chk(8'h00, 8'h01, "irq wait ran out");
      test_done();
    end
  endtask
  task automatic t_reset();
    chk({7'h00, irq_out}, 8'h00, "irq after reset");
    rd_chk(`UIP_OFS_IDENTITY, `UIP_IDLE_IDENT, "idle id");
    reg_wr(`UIP_OFS_ENABLE, 8'hf0);
    rd_chk(`UIP_OFS_ENABLE, 8'h00, "enable high bits");
    reg_wr(`UIP_OFS_IDENTITY, 8'hff);
    rd_chk(`UIP_OFS_IDENTITY, 8'h01, "id after write");
    rd_chk(3'h7, 8'h00, "unmapped read");
    $display("reset test done");
  endtask
  // Transmit interrupt raised by the shifter move, cleared two ways
  task automatic t_tx();
    reg_wr(`UIP_OFS_ENABLE, 8'h02);
    reg_wr(`UIP_OFS_DATA, 8'h3c);
    wait_irq(1'b1);
    chk(tx_byte, 8'h3c, "held byte");
    reg_wr(`UIP_OFS_DATA, 8'hc3);
    @(posedge clk);
    #1 chk({7'h00, irq_out}, 8'h00, "write clear");
    wait_irq(1'b1);
    rd_chk(`UIP_OFS_IDENTITY, 8'h02, "tx id");
    @(posedge clk);
    #1 chk({7'h00, irq_out}, 8'h00, "id read clear");
    rd_chk(`UIP_OFS_IDENTITY, 8'h01, "no rearm");
    $display("transmit test done");
  endtask
  // All four sources pending, serviced from highest to lowest
  task automatic t_priority();
    reg_wr(`UIP_OFS_DATA, 8'h33);
    wait_irq(1'b1);
    u_uip_line_model.set_modem(4'h1);
    u_uip_line_model.recv(8'h5a, 1'b1, 1'b0);
    reg_wr(`UIP_OFS_ENABLE, 8'h0f);
    rd_chk(`UIP_OFS_IDENTITY, 8'h06, "line first");
    rd_chk(`UIP_OFS_IDENTITY, 8'h06, "line held");
    rd_chk(`UIP_OFS_LINE_STAT, 8'h65, "status read");
    chk({3'h0, got[4:0]}, 8'h05, "ready and parity");
    rd_chk(`UIP_OFS_IDENTITY, 8'h04, "rx second");
    rd_chk(`UIP_OFS_DATA, 8'h5a, "rx byte");
    rd_chk(`UIP_OFS_IDENTITY, 8'h02, "tx third");
    rd_chk(`UIP_OFS_IDENTITY, 8'h00, "modem fourth");
    rd_chk(`UIP_OFS_MODEM_ST, 8'h11, "delta set");
    rd_chk(`UIP_OFS_MODEM_ST, 8'h10, "delta cleared");
    rd_chk(`UIP_OFS_IDENTITY, 8'h01, "all serviced");
    chk({7'h00, irq_out}, 8'h00, "irq idle");
    $display("priority test done");
  endtask
  // Flags still set while masked; unmasking receive then reports the ready flag
  task automatic t_disable();
    reg_wr(`UIP_OFS_ENABLE, 8'h00);
    u_uip_line_model.recv(8'ha5, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, irq_out}, 8'h00, "masked irq");
    rd_chk(`UIP_OFS_IDENTITY, 8'h01, "masked id");
    rd_chk(`UIP_OFS_LINE_STAT, 8'h69, "status read");
    chk({3'h0, got[4:0]}, 8'h09, "ready and framing");
    reg_wr(`UIP_OFS_ENABLE, 8'h01);
    wait_irq(1'b1);
    rd_chk(`UIP_OFS_IDENTITY, 8'h04, "rx unmasked");
    rd_chk(`UIP_OFS_DATA, 8'ha5, "rx byte");
    wait_irq(1'b0);
    u_uip_line_model.brk();
    rd_chk(`UIP_OFS_LINE_STAT, 8'h70, "break flag");
    $display("disable test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_tx();
    t_priority();
    t_disable();
    test_done();
  end
endmodule // uip_irq_unit_bench
